// ---- include/cds_pkg.sv ----
// shared constants and types for the digital i/o command link
package cds_pkg;
  // ****************************************************************
  // identifier layout
  // ****************************************************************
  localparam int ID_W     = 29;
  localparam int SEL_LSB  = 0;
  localparam int NODE_LSB = 8;
  localparam int FUNC_LSB = 16;
  localparam int ACK_BIT  = 24;
  localparam int DATA_W   = 64;
  // ****************************************************************
  // codes and reset values
  // ****************************************************************
  localparam logic [7:0] FUNC_IO     = 8'h10;
  localparam logic [7:0] FUNC_HB     = 8'h1f;
  localparam logic [7:0] NODE_MASTER = 8'hfe;
  localparam logic [7:0] SEL_ALL     = 8'h00;
  localparam logic [7:0] SEL_OUT     = 8'h01;
  localparam logic [7:0] SEL_IN      = 8'h02;
  localparam logic [7:0] HB_BYTE     = 8'h00;
  localparam logic [3:0] DLC_ONE     = 4'h1;
  localparam logic [3:0] DLC_TWO     = 4'h2;
  localparam logic [7:0] OUT_RESET   = 8'h00;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ         = 250_000_000;
  localparam int AUTO_PERIOD_MS = 1000;
  localparam int HB_TIMEOUT_MS  = 100;
  localparam int HB_SEND_MS     = 50;
  localparam int AUTO_PERIOD_CYC = CLK_HZ / 1000 * AUTO_PERIOD_MS;
  localparam int HB_TIMEOUT_CYC  = CLK_HZ / 1000 * HB_TIMEOUT_MS;
  localparam int HB_SEND_CYC     = CLK_HZ / 1000 * HB_SEND_MS;
  // ****************************************************************
  // state encodings
  // ****************************************************************
  typedef enum logic [1:0] {CDS_IDLE = 2'b01, CDS_SEND = 2'b10} cds_state_t;
endpackage

// ---- include/cds_if.sv ----
// frame-level link between the bus master and the i/o slave
interface cds_if;
  logic        req_valid;
  logic        req_ready;
  logic [28:0] req_id;
  logic        req_rtr;
  logic [3:0]  req_dlc;
  logic [63:0] req_data;
  logic        rsp_valid;
  logic        rsp_ready;
  logic [28:0] rsp_id;
  logic        rsp_rtr;
  logic [3:0]  rsp_dlc;
  logic [63:0] rsp_data;
  // the i/o slave end
  modport dev (input req_valid, req_id, req_rtr, req_dlc, req_data, rsp_ready,
               output req_ready, rsp_valid, rsp_id, rsp_rtr, rsp_dlc, rsp_data);
  // the bus master end
  modport mst (output req_valid, req_id, req_rtr, req_dlc, req_data, rsp_ready,
               input req_ready, rsp_valid, rsp_id, rsp_rtr, rsp_dlc, rsp_data);
endinterface

// ---- design/cds_dev.sv ----
// i/o slave end: decodes command frames, drives the output byte, answers
module cds_dev #(
  parameter int AUTO_PERIOD_CYC = cds_pkg::AUTO_PERIOD_CYC,
  parameter int HB_TIMEOUT_CYC  = cds_pkg::HB_TIMEOUT_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  cds_if.dev              link,
  input  wire logic [7:0] i_input_byte,
  input  wire logic [7:0] i_node_id,
  input  wire logic [7:0] i_safe_value,
  output logic      [7:0] o_out_byte,
  output logic            o_hb_lost
);
  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (AUTO_PERIOD_CYC < 2 || HB_TIMEOUT_CYC < 2)
  begin : g_chk
    $error("cds_dev: period and timeout need at least two cycles");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  // true when id carries the given function and node with ack clear
  function automatic logic id_hit(input logic [28:0] id, input logic [7:0] fn, input logic [7:0] nd);
    id_hit = !id[cds_pkg::ACK_BIT] && id[cds_pkg::FUNC_LSB +: 8] == fn && id[cds_pkg::NODE_LSB +: 8] == nd;
  endfunction

  // answer identifier: reserved zero, ack set
  function automatic logic [28:0] ans_id(input logic [7:0] nd, input logic [7:0] sel);
    ans_id = {4'h0, 1'b1, cds_pkg::FUNC_IO, nd, sel};
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [7:0] in_s1_q;
  logic [7:0] in_s2_q;
  logic [7:0] node_s1_q;
  logic [7:0] node_s2_q;

  // two flops on the input pins and the rotary switch
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      in_s1_q   <= 8'h00;
      in_s2_q   <= 8'h00;
      node_s1_q <= 8'h00;
      node_s2_q <= 8'h00;
    end
    else
    begin
      in_s1_q   <= i_input_byte;
      in_s2_q   <= in_s1_q;
      node_s1_q <= i_node_id;
      node_s2_q <= node_s1_q;
    end
  end

  // ****************************************************************
  // command engine
  // ****************************************************************
  cds_pkg::cds_state_t state_q, state_d;
  logic [7:0]  out_q, out_d;
  logic [7:0]  drive_q, drive_d;
  logic [31:0] hb_cnt_q, hb_cnt_d;
  logic        lost_q, lost_d;
  logic [31:0] per_cnt_q, per_cnt_d;
  logic        pend_q, pend_d;
  logic        rdy_q, rdy_d;
  logic        rv_q, rv_d;
  logic [28:0] rid_q, rid_d;
  logic [3:0]  rdlc_q, rdlc_d;
  logic [63:0] rdat_q, rdat_d;
  logic        take;
  logic        tick;
  logic        is_cmd;
  logic        is_hb;
  logic [7:0]  sel;

  always_comb
  begin
    take      = link.req_valid && rdy_q;
    sel       = link.req_id[cds_pkg::SEL_LSB +: 8];
    is_cmd    = take && id_hit(link.req_id, cds_pkg::FUNC_IO, node_s2_q);
    is_hb     = take && !link.req_rtr && link.req_dlc == cds_pkg::DLC_ONE
                && link.req_data[7:0] == cds_pkg::HB_BYTE
                && id_hit(link.req_id, cds_pkg::FUNC_HB, cds_pkg::NODE_MASTER);
    tick      = per_cnt_q == 32'(AUTO_PERIOD_CYC - 1);
    state_d   = state_q;
    out_d     = out_q;
    rv_d      = rv_q;
    rid_d     = rid_q;
    rdlc_d    = rdlc_q;
    rdat_d    = rdat_q;
    // free-running autonomous report timer
    per_cnt_d = tick ? 32'h0000_0000 : per_cnt_q + 32'h0000_0001;
    pend_d    = pend_q;
    // heartbeat watchdog: a heartbeat restarts it, expiry drives i_safe_value on the outputs
    hb_cnt_d  = lost_q ? hb_cnt_q : hb_cnt_q + 32'h0000_0001;
    lost_d    = lost_q || hb_cnt_q == 32'(HB_TIMEOUT_CYC - 1);
    if (is_hb)
    begin
      hb_cnt_d = 32'h0000_0000;
      lost_d   = 1'b0;
    end
    case (state_q)
      cds_pkg::CDS_IDLE:
      begin
        if (is_cmd && !link.req_rtr && sel == cds_pkg::SEL_OUT && link.req_dlc == cds_pkg::DLC_ONE)
        begin
          if (!lost_q)
          begin
            out_d   = link.req_data[7:0];
            rid_d   = ans_id(node_s2_q, sel);
            rdlc_d  = cds_pkg::DLC_ONE;
            rdat_d  = {56'h0, link.req_data[7:0]};
            rv_d    = 1'b1;
            state_d = cds_pkg::CDS_SEND;
          end
        end
        else if (is_cmd && link.req_rtr && sel == cds_pkg::SEL_OUT && link.req_dlc == cds_pkg::DLC_ONE)
        begin
          rid_d   = ans_id(node_s2_q, sel);
          rdlc_d  = cds_pkg::DLC_ONE;
          rdat_d  = {56'h0, drive_q};
          rv_d    = 1'b1;
          state_d = cds_pkg::CDS_SEND;
        end
        else if (is_cmd && link.req_rtr && sel == cds_pkg::SEL_IN && link.req_dlc == cds_pkg::DLC_ONE)
        begin
          rid_d   = ans_id(node_s2_q, sel);
          rdlc_d  = cds_pkg::DLC_ONE;
          rdat_d  = {56'h0, in_s2_q};
          rv_d    = 1'b1;
          state_d = cds_pkg::CDS_SEND;
        end
        else if (is_cmd && link.req_rtr && sel == cds_pkg::SEL_ALL && link.req_dlc == cds_pkg::DLC_TWO)
        begin
          rid_d   = ans_id(node_s2_q, sel);
          rdlc_d  = cds_pkg::DLC_TWO;
          rdat_d  = {48'h0, in_s2_q, drive_q};
          rv_d    = 1'b1;
          state_d = cds_pkg::CDS_SEND;
        end
        else if (!take && pend_q)
        begin
          rid_d   = ans_id(node_s2_q, cds_pkg::SEL_ALL);
          rdlc_d  = cds_pkg::DLC_TWO;
          rdat_d  = {48'h0, in_s2_q, drive_q};
          rv_d    = 1'b1;
          pend_d  = 1'b0;
          state_d = cds_pkg::CDS_SEND;
        end
      end
      cds_pkg::CDS_SEND:
      begin
        if (link.rsp_ready)
        begin
          rv_d    = 1'b0;
          state_d = cds_pkg::CDS_IDLE;
        end
      end
      default:
      begin
        rv_d    = 1'b0;
        state_d = cds_pkg::CDS_IDLE;
      end
    endcase
    // a new tick wins over the clear of the pending report
    if (tick)
    begin
      pend_d = 1'b1;
    end
    rdy_d   = state_d == cds_pkg::CDS_IDLE && !take;
    drive_d = lost_d ? i_safe_value : out_d;
  end

  // registers of the command engine
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q   <= cds_pkg::CDS_IDLE;
      out_q     <= cds_pkg::OUT_RESET;
      drive_q   <= cds_pkg::OUT_RESET;
      hb_cnt_q  <= 32'h0000_0000;
      lost_q    <= 1'b0;
      per_cnt_q <= 32'h0000_0000;
      pend_q    <= 1'b0;
      rdy_q     <= 1'b0;
      rv_q      <= 1'b0;
      rid_q     <= 29'h0;
      rdlc_q    <= 4'h0;
      rdat_q    <= 64'h0;
    end
    else
    begin
      state_q   <= state_d;
      out_q     <= out_d;
      drive_q   <= drive_d;
      hb_cnt_q  <= hb_cnt_d;
      lost_q    <= lost_d;
      per_cnt_q <= per_cnt_d;
      pend_q    <= pend_d;
      rdy_q     <= rdy_d;
      rv_q      <= rv_d;
      rid_q     <= rid_d;
      rdlc_q    <= rdlc_d;
      rdat_q    <= rdat_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign link.req_ready = rdy_q;
  assign link.rsp_valid = rv_q;
  assign link.rsp_id    = rid_q;
  assign link.rsp_rtr   = 1'b0; // answers are always data frames
  assign link.rsp_dlc   = rdlc_q;
  assign link.rsp_data  = rdat_q;
  assign o_out_byte     = drive_q;
  assign o_hb_lost      = lost_q;
endmodule

// ---- design/cds_mst.sv ----
// bus master end: sends heartbeats and user commands, returns answers
module cds_mst #(
  parameter int HB_SEND_CYC = cds_pkg::HB_SEND_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  cds_if.mst               link,
  input  wire logic        i_hb_enable,
  input  wire logic        i_cmd_valid,
  input  wire logic [7:0]  i_cmd_node,
  input  wire logic [7:0]  i_cmd_sel,
  input  wire logic        i_cmd_read,
  input  wire logic [7:0]  i_cmd_wdata,
  output logic             o_cmd_ready,
  output logic             o_rsp_valid,
  output logic [7:0]       o_rsp_node,
  output logic [7:0]       o_rsp_sel,
  output logic [3:0]       o_rsp_dlc,
  output logic [15:0]      o_rsp_data
);
  if (HB_SEND_CYC < 2)
  begin : g_chk
    $error("cds_mst: heartbeat period needs at least two cycles");
  end

  // ****************************************************************
  // request side
  // ****************************************************************
  cds_pkg::cds_state_t state_q, state_d;
  logic [31:0] hb_cnt_q, hb_cnt_d;
  logic        hb_pend_q, hb_pend_d;
  logic        crdy_q, crdy_d;
  logic        qv_q, qv_d;
  logic [28:0] qid_q, qid_d;
  logic        qrtr_q, qrtr_d;
  logic [3:0]  qdlc_q, qdlc_d;
  logic [63:0] qdat_q, qdat_d;
  logic        hb_tick;

  always_comb
  begin
    hb_tick   = hb_cnt_q == 32'(HB_SEND_CYC - 1);
    hb_cnt_d  = hb_tick ? 32'h0000_0000 : hb_cnt_q + 32'h0000_0001;
    hb_pend_d = hb_pend_q;
    state_d   = state_q;
    qv_d      = qv_q;
    qid_d     = qid_q;
    qrtr_d    = qrtr_q;
    qdlc_d    = qdlc_q;
    qdat_d    = qdat_q;
    case (state_q)
      cds_pkg::CDS_IDLE:
      begin
        if (hb_pend_q)
        begin
          // heartbeat goes first so the slave never times out
          qid_d     = {5'h00, cds_pkg::FUNC_HB, cds_pkg::NODE_MASTER, 8'h00};
          qrtr_d    = 1'b0;
          qdlc_d    = cds_pkg::DLC_ONE;
          qdat_d    = {56'h0, cds_pkg::HB_BYTE};
          qv_d      = 1'b1;
          hb_pend_d = 1'b0;
          state_d   = cds_pkg::CDS_SEND;
        end
        else if (i_cmd_valid && crdy_q)
        begin
          qid_d   = {5'h00, cds_pkg::FUNC_IO, i_cmd_node, i_cmd_sel};
          qrtr_d  = i_cmd_read;
          qdlc_d  = i_cmd_sel == cds_pkg::SEL_ALL ? cds_pkg::DLC_TWO : cds_pkg::DLC_ONE;
          qdat_d  = {56'h0, i_cmd_read ? 8'h00 : i_cmd_wdata};
          qv_d    = 1'b1;
          state_d = cds_pkg::CDS_SEND;
        end
      end
      cds_pkg::CDS_SEND:
      begin
        if (link.req_ready)
        begin
          qv_d    = 1'b0;
          state_d = cds_pkg::CDS_IDLE;
        end
      end
      default:
      begin
        qv_d    = 1'b0;
        state_d = cds_pkg::CDS_IDLE;
      end
    endcase
    // a new tick wins over the clear
    if (hb_tick && i_hb_enable)
    begin
      hb_pend_d = 1'b1;
    end
    crdy_d = state_d == cds_pkg::CDS_IDLE && !hb_pend_d && !(i_cmd_valid && crdy_q);
  end

  // registers of the request side
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q   <= cds_pkg::CDS_IDLE;
      hb_cnt_q  <= 32'h0000_0000;
      hb_pend_q <= 1'b0;
      crdy_q    <= 1'b0;
      qv_q      <= 1'b0;
      qid_q     <= 29'h0;
      qrtr_q    <= 1'b0;
      qdlc_q    <= 4'h0;
      qdat_q    <= 64'h0;
    end
    else
    begin
      state_q   <= state_d;
      hb_cnt_q  <= hb_cnt_d;
      hb_pend_q <= hb_pend_d;
      crdy_q    <= crdy_d;
      qv_q      <= qv_d;
      qid_q     <= qid_d;
      qrtr_q    <= qrtr_d;
      qdlc_q    <= qdlc_d;
      qdat_q    <= qdat_d;
    end
  end

  // ****************************************************************
  // answer side: accept every answer, pass acked i/o frames on
  // ****************************************************************
  logic        arv_q, arv_d;
  logic [7:0]  anode_q, anode_d;
  logic [7:0]  asel_q, asel_d;
  logic [3:0]  adlc_q, adlc_d;
  logic [15:0] adat_q, adat_d;

  always_comb
  begin
    arv_d   = link.rsp_valid && link.rsp_id[cds_pkg::ACK_BIT]
              && link.rsp_id[cds_pkg::FUNC_LSB +: 8] == cds_pkg::FUNC_IO;
    anode_d = arv_d ? link.rsp_id[cds_pkg::NODE_LSB +: 8] : anode_q;
    asel_d  = arv_d ? link.rsp_id[cds_pkg::SEL_LSB +: 8] : asel_q;
    adlc_d  = arv_d ? link.rsp_dlc : adlc_q;
    adat_d  = arv_d ? link.rsp_data[15:0] : adat_q;
  end

  // registers of the answer side
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      arv_q   <= 1'b0;
      anode_q <= 8'h00;
      asel_q  <= 8'h00;
      adlc_q  <= 4'h0;
      adat_q  <= 16'h0000;
    end
    else
    begin
      arv_q   <= arv_d;
      anode_q <= anode_d;
      asel_q  <= asel_d;
      adlc_q  <= adlc_d;
      adat_q  <= adat_d;
    end
  end

  assign link.req_valid = qv_q;
  assign link.req_id    = qid_q;
  assign link.req_rtr   = qrtr_q;
  assign link.req_dlc   = qdlc_q;
  assign link.req_data  = qdat_q;
  assign link.rsp_ready = 1'b1; // master always sinks answers at once
  assign o_cmd_ready    = crdy_q;
  assign o_rsp_valid    = arv_q;
  assign o_rsp_node     = anode_q;
  assign o_rsp_sel      = asel_q;
  assign o_rsp_dlc      = adlc_q;
  assign o_rsp_data     = adat_q;
endmodule

// ---- dv/cds_chk.sv ----
// concurrent checks on the frame link between the master end and the i/o slave end
module cds_chk (
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [28:0] req_id,
  input wire logic        req_rtr,
  input wire logic [3:0]  req_dlc,
  input wire logic [63:0] req_data,
  input wire logic        rsp_valid,
  input wire logic        rsp_ready,
  input wire logic [28:0] rsp_id,
  input wire logic        rsp_rtr,
  input wire logic [3:0]  rsp_dlc,
  input wire logic [63:0] rsp_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // request shapes
  // ****************************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_io_take;
    req_valid && req_ready && !req_id[24] && req_id[23:16] == cds_pkg::FUNC_IO;
  endsequence
  sequence s_wr_take;
    s_io_take and (!req_rtr && req_id[7:0] == cds_pkg::SEL_OUT && req_dlc == cds_pkg::DLC_ONE);
  endsequence
  sequence s_rd_take;
    s_io_take and (req_rtr && req_id[7:0] == cds_pkg::SEL_OUT && req_dlc == cds_pkg::DLC_ONE);
  endsequence
  sequence s_hb_take;
    req_valid && req_ready && req_id[23:16] == cds_pkg::FUNC_HB && req_id[15:8] == cds_pkg::NODE_MASTER;
  endsequence
  // ****************************************************************
  // link assertions
  // ****************************************************************
  a_take_drops_ready: assert property (s_take |=> !req_ready)
    else $error("slave ready stayed high after a take");
  a_answer_one_cycle: assert property (rsp_valid && rsp_ready |=> !rsp_valid)
    else $error("answer held longer than one accepted cycle");
  a_ready_low_answer: assert property (rsp_valid |-> !req_ready)
    else $error("slave ready high while an answer is pending");
  a_answer_fields: assert property (rsp_valid |-> rsp_id[28:25] == 4'h0 && rsp_id[24]
    && rsp_id[23:16] == cds_pkg::FUNC_IO && !rsp_rtr)
    else $error("answer identifier or frame kind wrong");
  a_answer_length: assert property (rsp_valid |-> rsp_dlc ==
    ((rsp_id[7:0] == cds_pkg::SEL_ALL) ? cds_pkg::DLC_TWO : cds_pkg::DLC_ONE))
    else $error("answer length does not suit selector");
  a_write_echo: assert property (s_wr_take ##1 rsp_valid |-> rsp_id[15:0] == $past(req_id[15:0])
    && rsp_data[7:0] == $past(req_data[7:0]))
    else $error("write echo differs from write frame");
  a_read_answer: assert property (s_rd_take ##1 rsp_valid |-> rsp_id[15:0] == $past(req_id[15:0]))
    else $error("read answer carries wrong node or selector");
  a_hb_silent: assert property (s_hb_take |=> !rsp_valid)
    else $error("heartbeat frame was answered");
  a_hb_frame: assert property (req_valid && req_id[23:16] == cds_pkg::FUNC_HB |-> !req_id[24]
    && req_id[15:8] == cds_pkg::NODE_MASTER && !req_rtr && req_dlc == cds_pkg::DLC_ONE
    && req_data[7:0] == cds_pkg::HB_BYTE)
    else $error("heartbeat frame badly formed");
  a_req_hold: assert property (req_valid && !req_ready |=> req_valid && $stable(req_id)
    && $stable(req_data))
    else $error("request changed before it was taken");
  a_no_spurious: assert property (rsp_valid && rsp_id[7:0] != cds_pkg::SEL_ALL
    |-> $past(req_valid && req_ready))
    else $error("single byte answer without a taken request");
endmodule

// ---- dv/tb.sv ----
// self-checking bench joining the master end and the i/o slave end
`define CHK(got, want) \
  num_checks++; \
  if ((got) !== (want)) \
  begin \
    fails++; \
    $display("unexpected at %0t: got %h want %h", $time, got, want); \
  end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AUTO_CYC = 200;
  localparam int HB_TO    = 100;
  localparam int HB_SEND  = 40;
  localparam logic [7:0] NODE = 8'h0a;
  logic        clk;
  logic        resetn;
  logic        hb_enable;
  logic        cmd_valid;
  logic [7:0]  cmd_node;
  logic [7:0]  cmd_sel;
  logic        cmd_read;
  logic [7:0]  cmd_wdata;
  logic        cmd_ready;
  logic        ans_valid;
  logic [7:0]  ans_node;
  logic [7:0]  ans_sel;
  logic [3:0]  ans_dlc;
  logic [15:0] ans_data;
  logic [7:0]  input_byte;
  logic [7:0]  node_id;
  logic [7:0]  safe_value;
  logic [7:0]  out_byte;
  logic        hb_lost;
  logic        got;
  int          fails;
  int          num_checks;
  int          n;
  // ****************************************************************
  // the two ends and the checker
  // ****************************************************************
  cds_if i_cds_if ();
  cds_dev #(.AUTO_PERIOD_CYC(AUTO_CYC), .HB_TIMEOUT_CYC(HB_TO)) i_cds_dev (
    .i_clk(clk), .i_resetn(resetn), .link(i_cds_if), .i_input_byte(input_byte), .i_node_id(node_id),
    .i_safe_value(safe_value), .o_out_byte(out_byte), .o_hb_lost(hb_lost));
  cds_mst #(.HB_SEND_CYC(HB_SEND)) i_cds_mst (
    .i_clk(clk), .i_resetn(resetn), .link(i_cds_if), .i_hb_enable(hb_enable), .i_cmd_valid(cmd_valid),
    .i_cmd_node(cmd_node), .i_cmd_sel(cmd_sel), .i_cmd_read(cmd_read), .i_cmd_wdata(cmd_wdata),
    .o_cmd_ready(cmd_ready), .o_rsp_valid(ans_valid), .o_rsp_node(ans_node), .o_rsp_sel(ans_sel),
    .o_rsp_dlc(ans_dlc), .o_rsp_data(ans_data));
  cds_chk i_cds_chk (
    .i_clk(clk), .i_resetn(resetn), .req_valid(i_cds_if.req_valid), .req_ready(i_cds_if.req_ready),
    .req_id(i_cds_if.req_id), .req_rtr(i_cds_if.req_rtr), .req_dlc(i_cds_if.req_dlc),
    .req_data(i_cds_if.req_data), .rsp_valid(i_cds_if.rsp_valid), .rsp_ready(i_cds_if.rsp_ready),
    .rsp_id(i_cds_if.rsp_id), .rsp_rtr(i_cds_if.rsp_rtr), .rsp_dlc(i_cds_if.rsp_dlc),
    .rsp_data(i_cds_if.rsp_data));
  // ****************************************************************
  // clock, run limit and verdict
  // ****************************************************************
  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // overall run limit cuts a hang short
  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    close_out();
  end
  // ****************************************************************
  // access tasks
  // ****************************************************************
  // waits a bounded time for an answer with this node and selector
  task automatic wait_ans(input logic [7:0] sel, input logic [7:0] node, input int lim, output int cnt);
    cnt = 0;
    got = 1'b0;
    while (!got && cnt < lim)
    begin
      @(posedge clk);
      cnt++;
      got = ans_valid === 1'b1 && ans_sel === sel && ans_node === node;
    end
  endtask
  // one command through the master end, then its answer or its absence
  task automatic send(input logic rd, input logic [7:0] sel, input logic [7:0] node, input logic [7:0] wd,
                      input logic want, input logic [15:0] exp);
    int k;
    @(posedge clk);
    cmd_read  <= rd;
    cmd_sel   <= sel;
    cmd_node  <= node;
    cmd_wdata <= wd;
    cmd_valid <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (cmd_ready !== 1'b1 && k < 100);
    if (k >= 100)
    begin
      fails++;
      close_out();
    end
    else
    begin
      cmd_valid <= 1'b0;
      wait_ans(sel, node, 30, k);
      `CHK(got, want)
      if (want && got)
      begin
        `CHK(ans_dlc, (sel == cds_pkg::SEL_ALL) ? cds_pkg::DLC_TWO : cds_pkg::DLC_ONE)
        `CHK((sel == cds_pkg::SEL_ALL) ? ans_data : {8'h00, ans_data[7:0]}, exp)
      end
    end
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    fails      = 0;
    num_checks = 0;
    resetn     = 1'b0;
    hb_enable  = 1'b1;
    cmd_valid  = 1'b0;
    cmd_node   = 8'h00;
    cmd_sel    = 8'h00;
    cmd_read   = 1'b0;
    cmd_wdata  = 8'h00;
    input_byte = 8'haa;
    node_id    = NODE;
    safe_value = 8'hc3;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(out_byte, cds_pkg::OUT_RESET)
    send(1'b0, cds_pkg::SEL_OUT, NODE, 8'h55, 1'b1, 16'h0055);
    `CHK(out_byte, 8'h55)
    send(1'b1, cds_pkg::SEL_OUT, NODE, 8'h00, 1'b1, 16'h0055);
    send(1'b1, cds_pkg::SEL_IN, NODE, 8'h00, 1'b1, 16'h00aa);
    send(1'b1, cds_pkg::SEL_ALL, NODE, 8'h00, 1'b1, 16'haa55);
    send(1'b0, cds_pkg::SEL_OUT, 8'h0b, 8'h33, 1'b0, 16'h0000);
    `CHK(out_byte, 8'h55)
    send(1'b0, cds_pkg::SEL_OUT, NODE, 8'hff, 1'b1, 16'h00ff);
    send(1'b0, cds_pkg::SEL_OUT, NODE, 8'h00, 1'b1, 16'h0000);
    send(1'b0, cds_pkg::SEL_OUT, NODE, 8'h5a, 1'b1, 16'h005a);
    send(1'b1, cds_pkg::SEL_ALL, NODE, 8'h00, 1'b1, 16'haa5a);
    // periodic combined reports, spaced by the report period
    input_byte <= 8'h3c;
    // let the new input byte pass its two synchroniser flops first
    repeat (4) @(posedge clk);
    wait_ans(cds_pkg::SEL_ALL, NODE, AUTO_CYC + 20, n);
    `CHK(got, 1'b1)
    `CHK(ans_data, 16'h3c5a)
    wait_ans(cds_pkg::SEL_ALL, NODE, AUTO_CYC + 20, n);
    `CHK(got && n >= AUTO_CYC - 10 && n <= AUTO_CYC + 10, 1'b1)
    // master stops its heartbeat: lost within the timeout, safe value driven
    hb_enable <= 1'b0;
    n = 0;
    while (hb_lost !== 1'b1 && n < HB_TO + 20)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(n > HB_TO - HB_SEND - 5 && n <= HB_TO + 5, 1'b1)
    @(posedge clk);
    `CHK(out_byte, 8'hc3)
    safe_value <= 8'h81;
    repeat (2) @(posedge clk);
    `CHK(out_byte, 8'h81)
    send(1'b0, cds_pkg::SEL_OUT, NODE, 8'h77, 1'b0, 16'h0000);
    `CHK(out_byte, 8'h81)
    send(1'b1, cds_pkg::SEL_OUT, NODE, 8'h00, 1'b1, 16'h0081);
    // heartbeat returns: stored byte comes back, writes apply again
    hb_enable <= 1'b1;
    n = 0;
    while (hb_lost !== 1'b0 && n < HB_SEND + 20)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(hb_lost, 1'b0)
    @(posedge clk);
    `CHK(out_byte, 8'h5a)
    send(1'b0, cds_pkg::SEL_OUT, NODE, 8'h99, 1'b1, 16'h0099);
    `CHK(out_byte, 8'h99)
    close_out();
  end
endmodule
